/* beam_eval_params.svh */
// constants for beam evaluation configuration: indices, fields, resets, codes, timing
`ifndef BEAM_EVAL_PARAMS_SVH
`define BEAM_EVAL_PARAMS_SVH

// ----------------------------------------------------------------
// parameter indices
// ----------------------------------------------------------------
`define IDX_GLOBAL      8'h47
`define IDX_LAYOUT      8'h48
`define IDX_ADDL        8'h4a
`define IDX_LOCK        8'h4e

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BEAM_MODE_LSB   24
`define COUNT_DIR_LSB   16
`define SMOOTH_LSB      8
`define INV_SMOOTH_LSB  0
`define TEACH_LSB       24
`define FILTER_LSB      16
`define INTEG_LSB       0
`define MOD1_LSB        120
`define MOD2_LSB        112

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GLOBAL_RST      32'h0000_0101
`define ADDL_RST        32'h0001_0000
`define LAYOUT_RST      128'hccca_0000_0000_0000_0000_0000_0000_0000
`define LOCK_RST        8'h00

// ----------------------------------------------------------------
// field limits and module codes
// ----------------------------------------------------------------
`define MODE_MAX        8'h02
`define DIR_MAX         8'h01
`define LOCK_MAX        8'h02
`define CODE_NOP        8'h00
`define CODE_STREAM_MAX 8'h6f
`define CODE_FIRST_BLK  8'hc8
`define CODE_FIRST_CLR  8'hc9
`define CODE_LAST_BLK   8'hca
`define CODE_LAST_CLR   8'hcb
`define CODE_BLK_CNT    8'hcc
`define CODE_CLR_CNT    8'hcd
`define CODE_AREA_LO    8'hd0
`define CODE_AREA_HI    8'hd1
`define CODE_AREA_OUT   8'hd2
`define CODE_STATUS     8'hd4

// ----------------------------------------------------------------
// sizes and timing
// ----------------------------------------------------------------
`define MAX_BEAMS       256
`define PD_BYTES        32
`define FIFO_DEPTH      8
`define ONE_MS_NS       1000000
`define CLK_PERIOD_NS   4
`define MS_CYCLES       (`ONE_MS_NS / `CLK_PERIOD_NS)

`endif

/* beam_eval_pkg.sv */
// types shared by the beam evaluation configuration block
package beam_eval_pkg;

	// processing sequencer, one-hot
	typedef enum logic [5:0] {
		ST_IDLE   = 6'b000001,
		ST_LOAD   = 6'b000010,
		ST_SMOOTH = 6'b000100,
		ST_INVSM  = 6'b001000,
		ST_EVAL   = 6'b010000,
		ST_BUILD  = 6'b100000
	} walk_state_t;

	// scanning geometry
	typedef enum logic [1:0] {
		MODE_PARALLEL = 2'h0,
		MODE_DIAGONAL = 2'h1,
		MODE_CROSSED  = 2'h2
	} beam_mode_t;

endpackage : beam_eval_pkg

/* pd_byte_fifo.sv */
// small flop-based fifo with valid/ready on both sides
module pd_byte_fifo #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             core_clk_in,
	input  wire logic             rst_b_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      fill_r;
	logic             push;
	logic             pop;

	// full and empty straight from the fill level
	assign in_ready_out  = (fill_r != (AW+1)'(DEPTH));
	assign out_valid_out = (fill_r != '0);
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;
	assign out_data_out  = mem_r[rd_ptr_r];

	// storage write
	always_ff @(posedge core_clk_in) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data_in;
		end
	end

	// pointers wrap on depth, which need not be a power of two
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			fill_r   <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
			end
			fill_r <= fill_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : pd_byte_fifo

/* beam_evaluation_config.sv */
// beam-state evaluation settings, filtering, smoothing and process data packing
//
// What this block does
// RL1: beam mode field picks parallel, diagonal or crossed scanning; others refused.
// RL2: beams numbered from connector end when direction is 0, else from far end.
// RL3: blocked runs shorter than smoothing value are ignored; range 1..255, default 1.
// RL4: free gaps shorter than inverted smoothing value are ignored; 1..255, default 1; the code keeps gaps at either end.
// RL5: beam state must stay consistent for filter-depth passes before use.
// RL6: results accumulate and hold over integration time in ms; 0 means no hold.
// RL7: panel lock codes: 0 enabled, 1 locked, 2 volatile; default 0.
// RL8: cyclic process data is capped at 32 bytes, so 256 beam bits.
// RL9: every beam state can be sent as one bit, whatever the geometry.
// RL10: module code 1..111 sends that many 16-beam cascades of raw beam bits.
// RL11: codes 200..205 send first/last blocked/clear beam and blocked/clear counts.
// RL12: codes 208, 209 send area states 1-16, 17-32; 210 sends mapped outputs.
// RL13: code 0 sends nothing, 212 sends status; undocumented codes are refused.
// RL14: module one sits at bit 120 of layout record, reset code 204.
// RL15: module two sits at bit 112 of layout record, reset code 202.
// RL16: layout is one 128-bit record of byte-wide module selections.
// RL17: evaluation works on logical beams, whose count follows the beam mode.
// RL18: filter, hold and smoothing once per cycle, then rebuild process data.
`include "beam_eval_params.svh"

module beam_evaluation_config
	import beam_eval_pkg::*;
#(
	parameter int unsigned MS_CYCLES = `MS_CYCLES
) (
	input  wire logic         core_clk_in,
	input  wire logic         rst_b_in,
	input  wire logic         param_req_in,
	input  wire logic         param_wr_in,
	input  wire logic [7:0]   param_index_in,
	input  wire logic [127:0] param_wdata_in,
	output logic              param_ack_out,
	output logic              param_err_out,
	output logic      [127:0] param_rdata_out,
	input  wire logic         cycle_strobe_in,
	input  wire logic [255:0] beam_state_in,
	input  wire logic [8:0]   beam_count_in,
	input  wire logic [31:0]  area_state_in,
	input  wire logic [15:0]  area_output_in,
	input  wire logic [7:0]   dev_status_in,
	output logic      [1:0]   beam_mode_out,
	output logic              count_dir_out,
	output logic      [1:0]   panel_lock_out,
	output logic              busy_out,
	output logic      [7:0]   pd_data_out,
	output logic              pd_last_out,
	output logic              pd_valid_out,
	input  wire logic         pd_ready_in
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// module code legality, used per layout byte
	function automatic logic code_ok(input logic [7:0] c);
		code_ok = (c <= `CODE_STREAM_MAX) || (c >= `CODE_FIRST_BLK && c <= `CODE_CLR_CNT) ||
			(c >= `CODE_AREA_LO && c <= `CODE_AREA_OUT) || (c == `CODE_STATUS);
	endfunction : code_ok

	// module k selection, module one in the top byte
	function automatic logic [7:0] mod_code(input logic [127:0] rec, input logic [3:0] k);
		mod_code = rec[`MOD1_LSB - 8*int'(k) +: 8];
	endfunction : mod_code

	// ----------------------------------------------------------------
	// settings registers
	// ----------------------------------------------------------------
	logic [31:0]  global_scan_settings_r;
	logic [127:0] process_data_layout_r;
	logic [31:0]  additional_eval_settings_r;
	logic [7:0]   panel_lock_r;

	wire  [7:0]   w_mode    = param_wdata_in[`BEAM_MODE_LSB +: 8];
	wire  [7:0]   w_dir     = param_wdata_in[`COUNT_DIR_LSB +: 8];
	wire  [7:0]   w_smooth  = param_wdata_in[`SMOOTH_LSB +: 8];
	wire  [7:0]   w_invsm   = param_wdata_in[`INV_SMOOTH_LSB +: 8];
	wire  [7:0]   w_teach   = param_wdata_in[`TEACH_LSB +: 8];
	wire  [7:0]   w_filter  = param_wdata_in[`FILTER_LSB +: 8];
	wire  [7:0]   w_lock    = param_wdata_in[7:0];
	wire  [15:0]  codes_ok;

	// every byte of a layout write is checked
	genvar gk;
	generate
		for (gk = 0; gk < 16; gk++) begin : g_code_chk
			assign codes_ok[gk] = code_ok(param_wdata_in[8*gk +: 8]);   // [RL13]
		end
	endgenerate

	wire          hit_global = (param_index_in == `IDX_GLOBAL);
	wire          hit_layout = (param_index_in == `IDX_LAYOUT);
	wire          hit_addl   = (param_index_in == `IDX_ADDL);
	wire          hit_lock   = (param_index_in == `IDX_LOCK);
	wire          hit_any    = hit_global | hit_layout | hit_addl | hit_lock;
	wire          ok_global  = (w_mode <= `MODE_MAX) && (w_dir <= `DIR_MAX) &&   // [RL1] [RL2]
		(w_smooth != 8'h00) && (w_invsm != 8'h00);                            // [RL3] [RL4]
	wire          ok_addl    = (w_teach == 8'h00) && (w_filter != 8'h00);      // [RL5]
	wire          ok_lock    = (w_lock <= `LOCK_MAX);                          // [RL7]
	wire          ok_write   = (hit_global & ok_global) | (hit_layout & (&codes_ok)) |
		(hit_addl & ok_addl) | (hit_lock & ok_lock);
	wire          wr_take    = param_req_in && param_wr_in && ok_write;
	wire          bad_req    = !hit_any || (param_wr_in && !ok_write);

	// read data, zero above each record
	wire  [127:0] rd_mux = hit_global ? {96'h0, global_scan_settings_r} :
		hit_layout ? process_data_layout_r :
		hit_addl ? {96'h0, additional_eval_settings_r} :
		hit_lock ? {120'h0, panel_lock_r} : 128'h0;

	// a refused write leaves the record untouched
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			global_scan_settings_r     <= `GLOBAL_RST;
			process_data_layout_r      <= `LAYOUT_RST;                          // [RL14] [RL15]
			additional_eval_settings_r <= `ADDL_RST;
			panel_lock_r               <= `LOCK_RST;                            // [RL7]
		end else if (wr_take) begin
			if (hit_global) global_scan_settings_r <= param_wdata_in[31:0];
			if (hit_layout) process_data_layout_r <= param_wdata_in;         // [RL16]
			if (hit_addl) additional_eval_settings_r <= param_wdata_in[31:0];
			if (hit_lock) panel_lock_r <= param_wdata_in[7:0];
		end
	end

	// one-cycle answer to every request
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			param_ack_out   <= 1'b0;
			param_err_out   <= 1'b0;
			param_rdata_out <= 128'h0;
		end else begin
			param_ack_out   <= param_req_in;
			param_err_out   <= param_req_in && bad_req;
			param_rdata_out <= (param_req_in && !param_wr_in) ? rd_mux : 128'h0;
		end
	end

	wire  [7:0]   smooth_i  = global_scan_settings_r[`SMOOTH_LSB +: 8];
	wire  [7:0]   invsm_i   = global_scan_settings_r[`INV_SMOOTH_LSB +: 8];
	wire          dir_inv   = global_scan_settings_r[`COUNT_DIR_LSB];
	wire  [7:0]   filt_dep  = additional_eval_settings_r[`FILTER_LSB +: 8];
	wire  [15:0]  integ_ms  = additional_eval_settings_r[`INTEG_LSB +: 16];

	assign beam_mode_out  = global_scan_settings_r[`BEAM_MODE_LSB +: 2];  // [RL1]
	assign count_dir_out  = dir_inv;
	assign panel_lock_out = panel_lock_r[1:0];

	// ----------------------------------------------------------------
	// per-beam consistency filter
	// ----------------------------------------------------------------
	walk_state_t  state_r;
	logic         take;
	logic [255:0] filt_w;

	// a strobe during processing is dropped: the optics must pace cycles
	assign take = cycle_strobe_in && (state_r == ST_IDLE);               // [RL18]

	genvar gb;
	generate
		for (gb = 0; gb < `MAX_BEAMS; gb++) begin : g_filt
			logic [7:0] same_r;
			logic       acc_r;
			wire        differ = beam_state_in[gb] ^ acc_r;
			wire        reach  = ({1'b0, same_r} + 9'h001) >= {1'b0, filt_dep};
			assign filt_w[gb] = acc_r;
			// new state adopted only after filter-depth agreeing passes
			always_ff @(posedge core_clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					same_r <= 8'h00;
					acc_r  <= 1'b0;
				end else if (take) begin
					same_r <= (differ && !reach) ? same_r + 8'h01 : 8'h00; // [RL5]
					if (differ && reach) acc_r <= beam_state_in[gb];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// integration hold timer
	// ----------------------------------------------------------------
	logic [17:0]  ms_cnt_r;
	logic [15:0]  held_ms_r;
	logic [255:0] hold_vec_r;
	wire          win_done = (integ_ms == 16'h0000) || (held_ms_r >= integ_ms); // [RL6]
	wire          restart  = (state_r == ST_LOAD) && win_done;
	wire          ms_tick  = (ms_cnt_r == 18'(MS_CYCLES - 1));

	// millisecond count cleared on each window restart, saturating hold age
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ms_cnt_r  <= 18'h00000;
			held_ms_r <= 16'h0000;
		end else if (restart) begin
			ms_cnt_r  <= 18'h00000;
			held_ms_r <= 16'h0000;
		end else begin
			ms_cnt_r  <= ms_tick ? 18'h00000 : ms_cnt_r + 18'h00001;
			if (ms_tick && held_ms_r != 16'hffff) held_ms_r <= held_ms_r + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// walk over logical beams
	// ----------------------------------------------------------------
	logic [255:0] work_r;
	logic [255:0] ordered_r;
	logic [8:0]   idx_r;
	logic [8:0]   run_len_r;
	logic [8:0]   run_start_r;
	logic [15:0]  fb_r, fc_r, lb_r, lc_r, tb_r, tc_r;

	// logical count comes from the optics and already reflects beam mode
	wire  [8:0]   cnt_eff  = (beam_count_in > 9'h100) ? 9'h100 : beam_count_in;  // [RL17]
	wire          at_end   = (idx_r >= cnt_eff);
	wire          cur_bit  = work_r[idx_r[7:0]];
	wire          tgt      = (state_r == ST_SMOOTH);
	wire  [7:0]   thr      = tgt ? smooth_i : invsm_i;
	wire          in_run   = !at_end && (cur_bit == tgt);
	// edge gaps are open space, not holes, so only bounded gaps are filled
	wire          short_run = (run_len_r != 9'h000) && (run_len_r < {1'b0, thr}) &&
		(tgt || (run_start_r != 9'h000 && !at_end));                        // [RL3] [RL4]
	wire  [255:0] run_mask = ({256{1'b1}} >> (9'h100 - run_len_r)) << run_start_r;
	wire  [8:0]   num0     = dir_inv ? (cnt_eff - 9'h001 - idx_r) : idx_r;   // [RL2]
	wire  [15:0]  num1     = {7'h00, num0} + 16'h0001;
	wire          walking  = (state_r == ST_SMOOTH) || (state_r == ST_INVSM);

	// run tracking and short-run flips
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			work_r      <= '0;
			hold_vec_r  <= '0;
			run_len_r   <= 9'h000;
			run_start_r <= 9'h000;
		end else if (state_r == ST_LOAD) begin
			work_r      <= win_done ? filt_w : (hold_vec_r | filt_w);          // [RL6]
			hold_vec_r  <= win_done ? filt_w : (hold_vec_r | filt_w);
			run_len_r   <= 9'h000;
		end else if (walking) begin
			if (in_run) begin
				if (run_len_r == 9'h000) run_start_r <= idx_r;
				run_len_r <= run_len_r + 9'h001;
			end else begin
				if (short_run) work_r <= work_r ^ run_mask;
				run_len_r <= 9'h000;
			end
		end
	end

	// statistics in counting order, 0 means none found
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			{fb_r, fc_r, lb_r, lc_r, tb_r, tc_r} <= '0;
			ordered_r <= '0;
		end else if (state_r == ST_LOAD) begin
			{fb_r, fc_r, lb_r, lc_r, tb_r, tc_r} <= '0;
			ordered_r <= '0;
		end else if (state_r == ST_EVAL && !at_end) begin
			ordered_r[num0[7:0]] <= cur_bit;                                  // [RL9]
			if (cur_bit) begin
				if (fb_r == 16'h0000 || num1 < fb_r) fb_r <= num1;        // [RL11]
				if (num1 > lb_r) lb_r <= num1;
				tb_r <= tb_r + 16'h0001;
			end else begin
				if (fc_r == 16'h0000 || num1 < fc_r) fc_r <= num1;
				if (num1 > lc_r) lc_r <= num1;
				tc_r <= tc_r + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// process data packing
	// ----------------------------------------------------------------
	logic [4:0]   mod_idx_r;
	logic [7:0]   mbyte_r;
	logic [5:0]   pd_cnt_r;
	logic [15:0]  stat16;
	logic         fifo_ready;
	wire          mods_done = mod_idx_r[4];
	wire  [7:0]   code      = mods_done ? `CODE_NOP : mod_code(process_data_layout_r, mod_idx_r[3:0]);
	wire          is_stream = (code != `CODE_NOP) && (code <= `CODE_STREAM_MAX);
	wire  [8:0]   code_len  = is_stream ? {code, 1'b0} :                       // [RL10]
		(code == `CODE_NOP) ? 9'h000 : 9'h002;                             // [RL13]
	wire  [7:0]   strm_byte = (mbyte_r < 8'h20) ? ordered_r[{mbyte_r[4:0], 3'b000} +: 8] : 8'h00;
	wire  [7:0]   pd_byte   = mods_done ? 8'h00 : is_stream ? strm_byte :
		(mbyte_r == 8'h00) ? stat16[15:8] : stat16[7:0];
	wire          building  = (state_r == ST_BUILD);
	wire          push      = building && (mods_done || code_len != 9'h000);
	wire          accepted  = push && fifo_ready;
	wire          last_byte = (pd_cnt_r == 6'(`PD_BYTES - 1));
	wire          mod_end   = !mods_done && building &&
		(code_len == 9'h000 || (accepted && ({1'b0, mbyte_r} + 9'h001) >= code_len));

	// two-byte value for the non-stream codes, high byte first
	always_comb begin
		case (code)
			`CODE_FIRST_BLK: stat16 = fb_r;                                 // [RL11]
			`CODE_FIRST_CLR: stat16 = fc_r;
			`CODE_LAST_BLK:  stat16 = lb_r;
			`CODE_LAST_CLR:  stat16 = lc_r;
			`CODE_BLK_CNT:   stat16 = tb_r;
			`CODE_CLR_CNT:   stat16 = tc_r;
			`CODE_AREA_LO:   stat16 = area_state_in[15:0];                  // [RL12]
			`CODE_AREA_HI:   stat16 = area_state_in[31:16];
			`CODE_AREA_OUT:  stat16 = area_output_in;
			`CODE_STATUS:    stat16 = {8'h00, dev_status_in};              // [RL13]
			default:         stat16 = 16'h0000;
		endcase
	end

	// module and byte cursor; frame always 32 bytes, padded with zeros
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mod_idx_r <= 5'h00;
			mbyte_r   <= 8'h00;
			pd_cnt_r  <= 6'h00;
		end else if (state_r == ST_EVAL) begin
			mod_idx_r <= 5'h00;
			mbyte_r   <= 8'h00;
			pd_cnt_r  <= 6'h00;
		end else if (building) begin
			if (accepted) pd_cnt_r <= pd_cnt_r + 6'h01;                      // [RL8]
			if (mod_end) begin
				mod_idx_r <= mod_idx_r + 5'h01;
				mbyte_r   <= 8'h00;
			end else if (accepted && !mods_done) begin
				mbyte_r <= mbyte_r + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	walk_state_t  state_nxt;

	always_comb begin
		case (state_r)
			ST_IDLE:   state_nxt = take ? ST_LOAD : ST_IDLE;
			ST_LOAD:   state_nxt = ST_SMOOTH;
			ST_SMOOTH: state_nxt = at_end ? ST_INVSM : ST_SMOOTH;
			ST_INVSM:  state_nxt = at_end ? ST_EVAL : ST_INVSM;
			ST_EVAL:   state_nxt = at_end ? ST_BUILD : ST_EVAL;
			ST_BUILD:  state_nxt = (accepted && last_byte) ? ST_IDLE : ST_BUILD; // [RL18]
			default:   state_nxt = ST_IDLE;
		endcase
	end

	// beam index restarts on every walk pass
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r <= ST_IDLE;
			idx_r   <= 9'h000;
		end else begin
			state_r <= state_nxt;
			idx_r   <= (state_nxt != state_r) ? 9'h000 : idx_r + 9'h001;
		end
	end

	assign busy_out = (state_r != ST_IDLE);

	// builder stalls while the fifo is full
	pd_byte_fifo #(
		.WIDTH (9),
		.DEPTH (`FIFO_DEPTH)
	) u_pd_fifo (
		.core_clk_in   (core_clk_in),
		.rst_b_in      (rst_b_in),
		.in_valid_in   (push),
		.in_ready_out  (fifo_ready),
		.in_data_in    ({last_byte, pd_byte}),
		.out_valid_out (pd_valid_out),
		.out_ready_in  (pd_ready_in),
		.out_data_out  ({pd_last_out, pd_data_out})
	);

endmodule : beam_evaluation_config

/* beam_evaluation_config_assertions.sv */
// concurrent checks on the parameter and process data ports
`include "beam_eval_params.svh"
module beam_evaluation_config_assertions
	import beam_eval_pkg::*;
#(
	parameter int unsigned MS_CYCLES = 4
) (
	input wire logic         core_clk_in,
	input wire logic         rst_b_in,
	input wire logic         param_req_in,
	input wire logic         param_wr_in,
	input wire logic [7:0]   param_index_in,
	input wire logic [127:0] param_wdata_in,
	input wire logic         param_ack_out,
	input wire logic         param_err_out,
	input wire logic [127:0] param_rdata_out,
	input wire logic         cycle_strobe_in,
	input wire logic [1:0]   panel_lock_out,
	input wire logic         busy_out,
	input wire logic [7:0]   pd_data_out,
	input wire logic         pd_last_out,
	input wire logic         pd_valid_out,
	input wire logic         pd_ready_in
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	// index decode kept apart so a wrong index list shows up
	wire known_idx = param_index_in inside {`IDX_GLOBAL, `IDX_LAYOUT, `IDX_ADDL, `IDX_LOCK};
	wire bad_mode  = param_wdata_in[31:24] > `MODE_MAX;
	sequence s_lock_wr;
		param_req_in && param_wr_in && param_index_in == `IDX_LOCK && param_wdata_in[7:0] <= `LOCK_MAX;
	endsequence
	sequence s_lock_ok;
		param_ack_out && !param_err_out;
	endsequence
	ack_follows_req_a: assert property (param_req_in |=> param_ack_out) else $error("ack missing");
	ack_needs_req_a: assert property (param_ack_out |-> $past(param_req_in)) else $error("stray ack");
	err_with_ack_a: assert property (param_err_out |-> param_ack_out) else $error("err without ack");
	rdata_idle_a: assert property (!param_ack_out |-> param_rdata_out == 128'h0) else $error("rdata not zero");
	bad_index_a: assert property (param_req_in && !known_idx |=> param_err_out) else $error("bad index taken");
	known_read_a: assert property (param_req_in && !param_wr_in && known_idx |=> !param_err_out)
		else $error("read refused");
	bad_mode_a: assert property (param_req_in && param_wr_in && param_index_in == `IDX_GLOBAL && bad_mode
		|=> param_err_out) else $error("bad mode taken");
	lock_update_a: assert property (s_lock_wr |=> s_lock_ok ##1 panel_lock_out == $past(param_wdata_in[1:0], 2))
		else $error("lock not updated");
	busy_start_a: assert property (cycle_strobe_in && !busy_out |=> busy_out)
		else $error("busy not raised");
	pd_hold_a: assert property (pd_valid_out && !pd_ready_in |=> pd_valid_out && $stable(pd_data_out)
		&& $stable(pd_last_out)) else $error("byte dropped on stall");
endmodule : beam_evaluation_config_assertions

bind beam_evaluation_config beam_evaluation_config_assertions #(.MS_CYCLES(MS_CYCLES)) u_chk (.core_clk_in,
	.rst_b_in, .param_req_in, .param_wr_in, .param_index_in, .param_wdata_in, .param_ack_out, .param_err_out,
	.param_rdata_out, .cycle_strobe_in, .panel_lock_out, .busy_out, .pd_data_out, .pd_last_out, .pd_valid_out,
	.pd_ready_in);

/* pd_consumer_model.sv */
// process data consumer: stalls every other cycle, keeps one frame
module pd_consumer_model (
	input  wire logic       core_clk_in,
	input  wire logic       rst_b_in,
	input  wire logic       pd_valid_in,
	input  wire logic [7:0] pd_data_in,
	input  wire logic       pd_last_in,
	input  wire logic       clear_in,
	output logic            pd_ready_out,
	output logic [7:0]      frame_out [32],
	output logic [5:0]      count_out,
	output logic [5:0]      last_pos_out
);
	// alternate ready so the fifo sees back pressure on every frame
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pd_ready_out <= 1'b0;
			count_out <= 6'h00;
			last_pos_out <= 6'h3f;
		end else begin
			pd_ready_out <= ~pd_ready_out;
			if (clear_in) begin
				count_out <= 6'h00;
				last_pos_out <= 6'h3f;
			end else if (pd_valid_in && pd_ready_out) begin
				frame_out[count_out[4:0]] <= pd_data_in;
				count_out <= count_out + 6'h01;
				if (pd_last_in) begin
					last_pos_out <= count_out;
				end
			end
		end
	end
endmodule : pd_consumer_model

/* beam_evaluation_config_tb.sv */
// testbench: parameter access, refused writes and process data frames
`include "beam_eval_params.svh"
module beam_evaluation_config_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_b, req, wr, strobe, clr, ack, err, dir, busy, pd_last, pd_valid, pd_ready;
	logic [7:0] idx, status, pd_data, frame [32];
	logic [127:0] wdata, rdata;
	logic [255:0] beams;
	logic [31:0] areas;
	logic [15:0] aouts;
	logic [8:0] bcount;
	logic [1:0] mode, lock;
	logic [5:0] cnt, lpos;
	logic [7:0] bi [10] = '{8'h47, 8'h47, 8'h47, 8'h47, 8'h4a, 8'h4a, 8'h4e, 8'h48, 8'h48, 8'h48};
	logic [31:0] bd [10] = '{32'h0300_0101, 32'h0002_0101, 32'h1, 32'h100, 32'h0, 32'h0101_0000, 32'h3, 32'h70,
		32'hd3, 32'hce};
	int n_errors = 0, num_checks = 0;
	always #2 clk = ~clk;
	beam_evaluation_config #(.MS_CYCLES(4)) u_dut (.core_clk_in(clk), .rst_b_in(rst_b), .param_req_in(req),
		.param_wr_in(wr), .param_index_in(idx), .param_wdata_in(wdata), .param_ack_out(ack), .param_err_out(err),
		.param_rdata_out(rdata), .cycle_strobe_in(strobe), .beam_state_in(beams), .beam_count_in(bcount),
		.area_state_in(areas), .area_output_in(aouts), .dev_status_in(status), .beam_mode_out(mode),
		.count_dir_out(dir), .panel_lock_out(lock), .busy_out(busy), .pd_data_out(pd_data),
		.pd_last_out(pd_last), .pd_valid_out(pd_valid), .pd_ready_in(pd_ready));
	pd_consumer_model u_far (.core_clk_in(clk), .rst_b_in(rst_b), .pd_valid_in(pd_valid), .pd_data_in(pd_data),
		.pd_last_in(pd_last), .clear_in(clr), .pd_ready_out(pd_ready), .frame_out(frame), .count_out(cnt),
		.last_pos_out(lpos));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim
	// one request, answer looked at in its single cycle
	task automatic acc(input logic w, input logic [7:0] i, input logic [127:0] d, input logic e, input logic [127:0] r);
		@(negedge clk);
		req = 1;
		wr = w;
		idx = i;
		wdata = d;
		@(negedge clk);
		req = 0;
		chk(ack, 1);
		chk(err, e);
		chk(rdata, r);
	endtask : acc
	// one measurement cycle; bytes 0..1 stream, 3 blocked count, 5 status
	task automatic run_frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] c);
		int k;
		@(negedge clk);
		clr = 1;
		@(negedge clk);
		clr = 0;
		strobe = 1;
		@(negedge clk);
		strobe = 0;
		k = 0;
		while (cnt != 6'd32 && k < 3000) begin
			@(negedge clk);
			k++;
		end
		if (k == 3000) begin
			n_errors++;
			end_sim();
		end
		chk(busy, 0);
		chk(lpos, 31);
		for (k = 0; k < 32; k++) chk(frame[k], k == 0 ? b0 : k == 1 ? b1 : k == 3 ? c : k == 5 ? status : 8'h00);
	endtask : run_frame
	initial begin
		rst_b = 0; req = 0; wr = 0; idx = 0; wdata = 0; strobe = 0; clr = 0;
		beams = 256'h38; bcount = 9'h10; areas = 32'h1234_5678; aouts = 16'h00ff; status = 8'h5a;
		repeat (16) @(negedge clk);
		rst_b = 1;
		acc(0, `IDX_GLOBAL, 0, 0, `GLOBAL_RST);
		acc(0, `IDX_LAYOUT, 0, 0, `LAYOUT_RST);
		acc(0, `IDX_ADDL, 0, 0, `ADDL_RST);
		acc(0, `IDX_LOCK, 0, 0, `LOCK_RST);
		acc(0, 8'h50, 0, 1, 0);
		for (int j = 0; j < 10; j++) acc(1, bi[j], bd[j], 1, 0);
		acc(0, `IDX_GLOBAL, 0, 0, `GLOBAL_RST);
		for (int m = 0; m < 3; m++) begin
			acc(1, `IDX_GLOBAL, 32'h101 | (m << 24), 0, 0);
			acc(1, `IDX_LOCK, m, 0, 0);
			chk({mode, lock}, {m[1:0], m[1:0]});
		end
		acc(1, `IDX_LAYOUT, {32'h01cc_d400, 96'h0}, 0, 0);
		acc(0, `IDX_LAYOUT, 0, 0, {32'h01cc_d400, 96'h0});
		run_frame(8'h38, 8'h00, 8'h03);
		acc(1, `IDX_GLOBAL, 32'h0201_0101, 0, 0);
		chk({mode, dir}, 3'h5);
		run_frame(8'h00, 8'h1c, 8'h03);
		acc(1, `IDX_GLOBAL, 32'h0000_0401, 0, 0);
		run_frame(8'h00, 8'h00, 8'h00);
		beams = 256'h3b;
		acc(1, `IDX_GLOBAL, 32'h0000_0102, 0, 0);
		run_frame(8'h3f, 8'h00, 8'h06);
		beams = 256'h0;
		acc(1, `IDX_ADDL, 32'h0002_0000, 0, 0);
		run_frame(8'h3f, 8'h00, 8'h06);
		run_frame(8'h00, 8'h00, 8'h00);
		acc(1, `IDX_ADDL, 32'h0001_ffff, 0, 0);
		beams = 256'h38;
		run_frame(8'h38, 8'h00, 8'h03);
		beams = 256'h0;
		run_frame(8'h38, 8'h00, 8'h03);
		end_sim();
	end
endmodule : beam_evaluation_config_tb
